// ==== rtl/serial_frame_format.sv ====
// Serial frame format register with the transmitter and receiver it steers
//
// Summary of operation
// - Format register is eight bits, readable and writable at any time.
// - Format register clears to zero on reset and on low-power entry.
// - Bit 7 picks asynchronous framing (0) or clocked synchronous (1).
// - Bit 6 picks eight (0) or seven (1) data bits; sync uses eight.
// - Seven-bit async characters never send holding register bit 7.
// - Bit 5 adds and checks a parity bit, asynchronous framing only.
// - Bit 4 picks even (0) or odd (1) parity, only when parity is on.
// - Even parity: ones in data plus parity is even, sent and checked.
// - Odd parity: ones in data plus parity is odd, sent and checked.
// - Bit 3 picks one or two stop bits of 1; sync sends none.
// - Receiver checks only the first stop bit, then seeks a start.
// - Bit 2 enables multiprocessor bit; parity settings then ignored.
// - Bits 1:0 feed the baud counter with clock /1, /4, /16 or /64.
// - Characters shift out least significant bit first.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module serial_frame_format (
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  input  wire logic                     low_power_enter,
  input  wire frame_fmt_pkg::reg_req_s  reg_req,
  output logic [7:0]                    rdata,
  input  wire logic                     rxd_pin,
  output logic                          txd,
  output logic                          sck_out
);
  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Parity bit that makes the total ones count match the sense
  function automatic logic parity_of(input logic [7:0] d,
                                     input logic       odd);
    parity_of = (^d) ^ odd;
  endfunction

  // Bit period elapses when the counter is spent on a prescale tick
  function automatic logic spent(input logic [7:0] cnt,
                                 input logic       tick);
    spent = tick && (cnt == frame_fmt_pkg::ZERO_BYTE);
  endfunction

  // ------------------------------------------------------------
  // Registers and decode
  // ------------------------------------------------------------
  frame_fmt_pkg::frame_format_s fmt;
  logic [7:0] bitrate;
  logic [7:0] hold;
  logic [2:0] ctrl;
  logic       hold_full;
  logic       rx_full;
  logic       par_err;
  logic       frm_err;
  logic       rx_mpb;
  logic [7:0] rx_data;
  logic       clear_all;
  logic       wr_fmt, wr_rate, wr_hold, wr_ctrl, wr_stat, rd_rx;
  logic [7:0] status;
  logic [7:0] rsel;

  assign clear_all = sys_rst || low_power_enter;
  assign wr_fmt  = reg_req.wr && reg_req.addr == frame_fmt_pkg::ADDR_FORMAT;
  assign wr_rate = reg_req.wr && reg_req.addr == frame_fmt_pkg::ADDR_BITRATE;
  assign wr_hold = reg_req.wr && reg_req.addr == frame_fmt_pkg::ADDR_HOLD;
  assign wr_ctrl = reg_req.wr && reg_req.addr == frame_fmt_pkg::ADDR_CTRL;
  assign wr_stat = reg_req.wr && reg_req.addr == frame_fmt_pkg::ADDR_STATUS;
  assign rd_rx   = reg_req.rd && reg_req.addr == frame_fmt_pkg::ADDR_RXDATA;

  // Read selection; unmapped addresses read as zero
  always_comb begin
    if (reg_req.addr == frame_fmt_pkg::ADDR_FORMAT) begin
      rsel = fmt;
    end else if (reg_req.addr == frame_fmt_pkg::ADDR_BITRATE) begin
      rsel = bitrate;
    end else if (reg_req.addr == frame_fmt_pkg::ADDR_HOLD) begin
      rsel = hold;
    end else if (reg_req.addr == frame_fmt_pkg::ADDR_CTRL) begin
      rsel = {5'h00, ctrl};
    end else if (reg_req.addr == frame_fmt_pkg::ADDR_STATUS) begin
      rsel = status;
    end else if (reg_req.addr == frame_fmt_pkg::ADDR_RXDATA) begin
      rsel = rx_data;
    end else begin
      rsel = frame_fmt_pkg::ZERO_BYTE;
    end
  end

  // Software-written registers and the registered read data
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      fmt     <= frame_fmt_pkg::FORMAT_RESET;
      bitrate <= frame_fmt_pkg::BITRATE_RESET;
      ctrl    <= 3'h0;
      rdata   <= frame_fmt_pkg::ZERO_BYTE;
    end else begin
      if (wr_fmt) fmt <= reg_req.wdata;
      if (wr_rate) bitrate <= reg_req.wdata;
      if (wr_ctrl) ctrl <= reg_req.wdata[2:0];
      rdata <= reg_req.rd ? rsel : frame_fmt_pkg::ZERO_BYTE;
    end
  end

  // ------------------------------------------------------------
  // Baud prescaler
  // ------------------------------------------------------------
  logic [5:0] pre_cnt;
  logic [5:0] pre_mask;
  logic       ptick;

  // Tick once per divided period of the system clock
  assign pre_mask =
    fmt.baud_prescale_select == frame_fmt_pkg::PS_DIV1  ?
      frame_fmt_pkg::MASK_DIV1  :
    fmt.baud_prescale_select == frame_fmt_pkg::PS_DIV4  ?
      frame_fmt_pkg::MASK_DIV4  :
    fmt.baud_prescale_select == frame_fmt_pkg::PS_DIV16 ?
      frame_fmt_pkg::MASK_DIV16 : frame_fmt_pkg::MASK_DIV64;
  assign ptick = (pre_cnt & pre_mask) == pre_mask;

  always_ff @(posedge mclk) begin
    if (clear_all) pre_cnt <= 6'h00;
    else pre_cnt <= pre_cnt + 6'h01;
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  frame_fmt_pkg::tx_state_e     tx_state;
  frame_fmt_pkg::frame_format_s tx_fmt;
  logic [7:0] tx_shift;
  logic [7:0] tx_word;
  logic [7:0] tx_cnt;
  logic [3:0] tx_bits;
  logic       tx_stop_left;
  logic       tx_mpb;
  logic       tx_end;
  logic       tx_extra;
  logic [3:0] tx_nbits;
  logic [7:0] load_word;
  logic       load;

  // Frame shape is latched at load so a mid-frame write cannot tear it
  assign tx_end   = spent(tx_cnt, ptick);
  assign tx_extra = !tx_fmt.sync &&
                    (tx_fmt.parity_enable ||
                     tx_fmt.multiproc_function_enable);
  assign tx_nbits = (!tx_fmt.sync && tx_fmt.char_length_select) ?
                    frame_fmt_pkg::BITS_SEVEN :
                    frame_fmt_pkg::BITS_EIGHT;
  assign load_word = (!fmt.sync && fmt.char_length_select) ?
                     {1'b0, hold[6:0]} : hold;
  assign load = tx_state == frame_fmt_pkg::TX_IDLE && hold_full &&
                ctrl[frame_fmt_pkg::CTRL_TX_EN];

  // Holding register and its full flag; a new write wins over the load
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      hold      <= frame_fmt_pkg::HOLD_RESET;
      hold_full <= 1'b0;
    end else begin
      if (wr_hold) hold <= reg_req.wdata;
      if (wr_hold) hold_full <= 1'b1;
      else if (load) hold_full <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (clear_all) begin
      tx_state     <= frame_fmt_pkg::TX_IDLE;
      tx_fmt       <= frame_fmt_pkg::FORMAT_RESET;
      tx_shift     <= frame_fmt_pkg::ZERO_BYTE;
      tx_word      <= frame_fmt_pkg::ZERO_BYTE;
      tx_cnt       <= frame_fmt_pkg::ZERO_BYTE;
      tx_bits      <= 4'h0;
      tx_stop_left <= 1'b0;
      tx_mpb       <= 1'b0;
      txd          <= 1'b1;
      sck_out      <= 1'b1;
    end else begin
      if (tx_end || load) tx_cnt <= bitrate;
      else if (ptick) tx_cnt <= tx_cnt - 8'h01;
      // Sync clock low in first half of each data bit, high after
      sck_out <= !(tx_state == frame_fmt_pkg::TX_DATA && tx_fmt.sync &&
                   tx_cnt > (bitrate >> 1));
      case (tx_state)
        frame_fmt_pkg::TX_IDLE: begin
          txd <= 1'b1;
          if (load) begin
            tx_fmt   <= fmt;
            tx_shift <= load_word;
            tx_word  <= load_word;
            tx_mpb   <= ctrl[frame_fmt_pkg::CTRL_TX_MPB];
            tx_bits  <= 4'h0;
            txd      <= fmt.sync ? load_word[0] : 1'b0;
            tx_state <= fmt.sync ? frame_fmt_pkg::TX_DATA :
                                   frame_fmt_pkg::TX_START;
          end
        end
        frame_fmt_pkg::TX_START: begin
          if (tx_end) begin
            txd      <= tx_shift[0];
            tx_state <= frame_fmt_pkg::TX_DATA;
          end
        end
        frame_fmt_pkg::TX_DATA: begin
          if (tx_end) begin
            tx_shift <= tx_shift >> 1;
            tx_bits  <= tx_bits + 4'h1;
            txd      <= tx_shift[1];
            if (tx_bits == tx_nbits - 4'h1) begin
              if (tx_extra) begin
                tx_state <= frame_fmt_pkg::TX_EXTRA;
                txd <= tx_fmt.multiproc_function_enable ? tx_mpb :
                       parity_of(tx_word,
                                 tx_fmt.parity_odd_select);
              end else if (tx_fmt.sync) begin
                tx_state <= frame_fmt_pkg::TX_IDLE;
                txd      <= 1'b1;
              end else begin
                tx_state     <= frame_fmt_pkg::TX_STOP;
                tx_stop_left <= tx_fmt.stop_two;
                txd          <= 1'b1;
              end
            end
          end
        end
        frame_fmt_pkg::TX_EXTRA: begin
          if (tx_end) begin
            tx_state     <= frame_fmt_pkg::TX_STOP;
            tx_stop_left <= tx_fmt.stop_two;
            txd          <= 1'b1;
          end
        end
        default: begin
          txd <= 1'b1;
          if (tx_end) begin
            if (tx_stop_left) tx_stop_left <= 1'b0;
            else tx_state <= frame_fmt_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Receiver (asynchronous framing)
  // ------------------------------------------------------------
  frame_fmt_pkg::rx_state_e rx_state;
  logic       rxd_meta, rxd_s;
  logic [7:0] rx_shift;
  logic [7:0] rx_cnt;
  logic [3:0] rx_bits;
  logic       rx_xbit;
  logic       rx_end;
  logic       rx_extra;
  logic       rx_pe;
  logic [3:0] rx_nbits;
  logic [7:0] rx_word;
  logic       rx_store;
  logic       rx_bad_par;

  assign rx_end   = spent(rx_cnt, ptick);
  assign rx_pe    = fmt.parity_enable &&
                    !fmt.multiproc_function_enable;
  assign rx_extra = fmt.parity_enable || fmt.multiproc_function_enable;
  assign rx_nbits = fmt.char_length_select ? frame_fmt_pkg::BITS_SEVEN :
                                             frame_fmt_pkg::BITS_EIGHT;
  // Seven-bit characters land in the upper bits of the shifter
  assign rx_word  = fmt.char_length_select ? {1'b0, rx_shift[7:1]} :
                                             rx_shift;
  assign rx_store = rx_state == frame_fmt_pkg::RX_STOP && rx_end;
  assign rx_bad_par = rx_pe && (parity_of(rx_word, fmt.parity_odd_select)
                                != rx_xbit);

  // Pin passes two flops before any logic looks at it
  always_ff @(posedge mclk) begin
    rxd_meta <= rxd_pin;
    rxd_s    <= rxd_meta;
  end

  always_ff @(posedge mclk) begin
    if (clear_all) begin
      rx_state <= frame_fmt_pkg::RX_IDLE;
      rx_shift <= frame_fmt_pkg::ZERO_BYTE;
      rx_cnt   <= frame_fmt_pkg::ZERO_BYTE;
      rx_bits  <= 4'h0;
      rx_xbit  <= 1'b0;
    end else begin
      if (rx_state == frame_fmt_pkg::RX_IDLE) rx_cnt <= bitrate >> 1;
      else if (rx_end) rx_cnt <= bitrate;
      else if (ptick) rx_cnt <= rx_cnt - 8'h01;
      case (rx_state)
        frame_fmt_pkg::RX_IDLE: begin
          rx_shift <= frame_fmt_pkg::ZERO_BYTE;
          rx_bits  <= 4'h0;
          if (!rxd_s && !fmt.sync && ctrl[frame_fmt_pkg::CTRL_RX_EN])
            rx_state <= frame_fmt_pkg::RX_START;
        end
        frame_fmt_pkg::RX_START: begin
          // A start bit gone high by mid-bit was a glitch
          if (rx_end) rx_state <= rxd_s ? frame_fmt_pkg::RX_IDLE :
                                          frame_fmt_pkg::RX_DATA;
        end
        frame_fmt_pkg::RX_DATA: begin
          if (rx_end) begin
            rx_shift <= {rxd_s, rx_shift[7:1]};
            rx_bits  <= rx_bits + 4'h1;
            if (rx_bits == rx_nbits - 4'h1)
              rx_state <= rx_extra ? frame_fmt_pkg::RX_EXTRA :
                                     frame_fmt_pkg::RX_STOP;
          end
        end
        frame_fmt_pkg::RX_EXTRA: begin
          if (rx_end) begin
            rx_xbit  <= rxd_s;
            rx_state <= frame_fmt_pkg::RX_STOP;
          end
        end
        default: begin
          if (rx_end) rx_state <= frame_fmt_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Receive flags: a set in the same cycle as a clear wins
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      rx_data <= frame_fmt_pkg::ZERO_BYTE;
      rx_full <= 1'b0;
      par_err <= 1'b0;
      frm_err <= 1'b0;
      rx_mpb  <= 1'b0;
    end else if (rx_store) begin
      rx_data <= rx_word;
      rx_full <= 1'b1;
      rx_mpb  <= fmt.multiproc_function_enable && rx_xbit;
      par_err <= rx_bad_par ||
                 (par_err && !(wr_stat &&
                   reg_req.wdata[frame_fmt_pkg::STAT_PAR_ERR]));
      frm_err <= !rxd_s ||
                 (frm_err && !(wr_stat &&
                   reg_req.wdata[frame_fmt_pkg::STAT_FRM_ERR]));
    end else begin
      if (rd_rx) rx_full <= 1'b0;
      if (wr_stat && reg_req.wdata[frame_fmt_pkg::STAT_PAR_ERR])
        par_err <= 1'b0;
      if (wr_stat && reg_req.wdata[frame_fmt_pkg::STAT_FRM_ERR])
        frm_err <= 1'b0;
    end
  end

  assign status = {2'h0, rx_mpb, frm_err, par_err, rx_full,
                   tx_state != frame_fmt_pkg::TX_IDLE, hold_full};

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence fmt_write_s;
    wr_fmt && !low_power_enter;
  endsequence
  // A low-power clear in the load cycle would cancel the frame
  sequence frame_load_s;
    load && !fmt.sync && !low_power_enter;
  endsequence
  sequence start_bit_s;
    !txd ##0 tx_state == frame_fmt_pkg::TX_START;
  endsequence
  // Divide-by-4 held, with no clear, from one tick to the next
  sequence div4_run_s;
    ptick && fmt.baud_prescale_select == frame_fmt_pkg::PS_DIV4 &&
    !low_power_enter ##1
    (fmt.baud_prescale_select == frame_fmt_pkg::PS_DIV4 &&
     !low_power_enter) [*4];
  endsequence

  fmt_write_a: assert property (
    fmt_write_s |=> fmt == $past(reg_req.wdata))
    else $error("format register did not take the write");
  fmt_clear_a: assert property (
    low_power_enter |=> fmt == frame_fmt_pkg::FORMAT_RESET)
    else $error("format register not cleared on low-power entry");
  start_bit_a: assert property (
    frame_load_s |=> start_bit_s)
    else $error("async character did not begin with a 0 start bit");
  lsb_first_a: assert property (
    tx_state == frame_fmt_pkg::TX_DATA |-> txd == tx_shift[0])
    else $error("transmit bit is not the shifter's low bit");
  mask_seven_a: assert property (
    tx_state == frame_fmt_pkg::TX_DATA && !tx_fmt.sync &&
    tx_fmt.char_length_select |->
    tx_bits < frame_fmt_pkg::BITS_SEVEN && !tx_word[7])
    else $error("seven-bit character sent bit 7");
  extra_bit_a: assert property (
    tx_state == frame_fmt_pkg::TX_EXTRA |-> txd ==
    (tx_fmt.multiproc_function_enable ? tx_mpb :
     (^tx_word) ^ tx_fmt.parity_odd_select))
    else $error("parity or multiprocessor bit wrong");
  stop_level_a: assert property (
    tx_state == frame_fmt_pkg::TX_STOP |-> txd && !tx_fmt.sync)
    else $error("stop bit low or sent in sync framing");
  div4_tick_a: assert property (
    div4_run_s |-> ptick && !$past(ptick) && !$past(ptick, 2) &&
    !$past(ptick, 3))
    else $error("divide-by-4 prescale tick spacing wrong");
  rx_stop_a: assert property (
    rx_store && !low_power_enter |=> rx_full &&
    rx_state == frame_fmt_pkg::RX_IDLE)
    else $error("receiver did not finish after the first stop bit");
endmodule

// ==== rtl/frame_fmt_pkg.sv ====
// Constants, types and register map of the serial frame format block
package frame_fmt_pkg;
  // --------------------------------------------------------------
  // Register map (word index on the plain register port)
  // --------------------------------------------------------------
  localparam logic [2:0] ADDR_FORMAT  = 3'h0;
  localparam logic [2:0] ADDR_BITRATE = 3'h1;
  localparam logic [2:0] ADDR_HOLD    = 3'h2;
  localparam logic [2:0] ADDR_CTRL    = 3'h3;
  localparam logic [2:0] ADDR_STATUS  = 3'h4;
  localparam logic [2:0] ADDR_RXDATA  = 3'h5;

  // Reset values
  localparam logic [7:0] FORMAT_RESET  = 8'h00;
  localparam logic [7:0] BITRATE_RESET = 8'hFF;
  localparam logic [7:0] HOLD_RESET    = 8'hFF;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;

  // Control register fields
  localparam int CTRL_TX_EN  = 0;
  localparam int CTRL_RX_EN  = 1;
  localparam int CTRL_TX_MPB = 2;

  // Status register fields (error bits are write-one-to-clear)
  localparam int STAT_HOLD_FULL = 0;
  localparam int STAT_TX_BUSY   = 1;
  localparam int STAT_RX_FULL   = 2;
  localparam int STAT_PAR_ERR   = 3;
  localparam int STAT_FRM_ERR   = 4;
  localparam int STAT_RX_MPB    = 5;

  // Character lengths and prescaler masks
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_SEVEN = 4'h7;
  localparam logic [1:0] PS_DIV1    = 2'h0;
  localparam logic [1:0] PS_DIV4    = 2'h1;
  localparam logic [1:0] PS_DIV16   = 2'h2;
  localparam logic [5:0] MASK_DIV1  = 6'h00;
  localparam logic [5:0] MASK_DIV4  = 6'h03;
  localparam logic [5:0] MASK_DIV16 = 6'h0F;
  localparam logic [5:0] MASK_DIV64 = 6'h3F;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef struct packed {
    logic       sync;
    logic       char_length_select;
    logic       parity_enable;
    logic       parity_odd_select;
    logic       stop_two;
    logic       multiproc_function_enable;
    logic [1:0] baud_prescale_select;
  } frame_format_s;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP} tx_state_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} rx_state_e;
endpackage

// ==== bench/serial_peer.sv ====
// Remote asynchronous serial device driving the receive line
`timescale 1ns/1ps
module serial_peer (
  input  wire logic mclk,
  output logic      rxd
);
  // Line idles high between frames, as an async line does
  initial rxd = 1'b1;

  // ----------------------------------------------------------------
  // Frame sender
  // ----------------------------------------------------------------
  // Bit 0 of the vector goes first; back-to-back characters are
  // joined into one vector so the line is never assigned twice
  task automatic send(input logic [31:0] bits, input int n,
                      input int p);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (p) @(posedge mclk);
    end
    rxd <= 1'b1;
  endtask
endmodule

// ==== bench/serial_frame_format_bench.sv ====
// Self-checking bench for the serial frame format block
`timescale 1ns/1ps
module serial_frame_format_bench;
  // Four clocks a bit: bitrate 3 with the undivided clock
  localparam int         P      = 4;
  localparam logic [2:0] A_FMT  = frame_fmt_pkg::ADDR_FORMAT;
  localparam logic [2:0] A_RATE = frame_fmt_pkg::ADDR_BITRATE;
  localparam logic [2:0] A_HOLD = frame_fmt_pkg::ADDR_HOLD;
  localparam logic [2:0] A_CTRL = frame_fmt_pkg::ADDR_CTRL;
  localparam logic [2:0] A_STAT = frame_fmt_pkg::ADDR_STATUS;
  localparam logic [2:0] A_RXD  = frame_fmt_pkg::ADDR_RXDATA;

  logic                    mclk;
  logic                    sys_rst;
  logic                    low_power_enter;
  frame_fmt_pkg::reg_req_s reg_req;
  logic [7:0]              rdata;
  logic                    rxd_pin;
  logic                    txd;
  logic                    sck_out;
  int                      fail_count;
  int                      num_checks;
  int                      cycles = 0;

  serial_frame_format dut (
    .mclk(mclk), .sys_rst(sys_rst), .low_power_enter(low_power_enter),
    .reg_req(reg_req), .rdata(rdata), .rxd_pin(rxd_pin), .txd(txd),
    .sck_out(sck_out));
  serial_peer peer (.mclk(mclk), .rxd(rxd_pin));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Cut a hang short; the whole run needs well under this
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // Each bus task idles one cycle so strobes never meet in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    reg_req <= '0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    reg_req <= '0;
    #1 d = rdata;
    @(posedge mclk);
  endtask

  // Expected line bits; unused upper bits stay high
  function automatic int frame(input logic [7:0] f, d, input logic m,
                               output logic [31:0] b);
    int n;
    logic x;
    b = '1;
    if (f[7]) begin
      b[7:0] = d;
      return 8;
    end
    b[0] = 1'b0;
    n = 1;
    for (int i = 0; i < (f[6] ? 7 : 8); i++) begin
      b[n] = d[i];
      n++;
    end
    x = f[6] ? ^d[6:0] : ^d;
    if (f[2] || f[5]) begin
      b[n] = f[2] ? m : (f[4] ? ~x : x);
      n++;
    end
    return n + (f[3] ? 2 : 1);
  endfunction

  // Find the start bit, then sample each bit in its middle
  task automatic cap_async(input int n, output logic [31:0] b);
    b = '1;
    #1;
    for (int i = 0; i < 60 && txd !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
    end
    repeat (P / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      #1 b[i] = txd;
      repeat (P) @(posedge mclk);
    end
  endtask

  // Take the data line at each rising edge of the shift clock
  task automatic cap_sync(output logic [31:0] b);
    logic pv;
    int   k;
    b = '1;
    pv = 1'b1;
    k = 0;
    for (int i = 0; i < 200 && k < 8; i++) begin
      #1;
      if (pv === 1'b0 && sck_out === 1'b1) begin
        b[k] = txd;
        k++;
      end
      pv = sck_out;
      @(posedge mclk);
    end
  endtask

  task automatic wait_lvl(input logic l, output int c);
    c = 0;
    #1;
    while (txd !== l && c < 600) begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  v, d, a, f;
    logic [31:0] e, g;
    logic        m;
    int          n;
    // Sync formats keep the multiprocessor bit clear
    logic [7:0] fm [9];
    sys_rst = 1'b1;
    low_power_enter = 1'b0;
    reg_req = '0;
    fail_count = 0;
    num_checks = 0;
    fm = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h60,
           8'h38, 8'h0C, 8'h24, 8'hB8};
    v = $urandom(32'hEF1B);
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(A_FMT, v);
    chk("format reset", 8'h00, v);
    rd(3'h7, v);
    chk("unmapped read", 8'h00, v);
    // Every bit writable and readable, all-ones first
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      wr(A_FMT, d);
      rd(A_FMT, v);
      chk("format rw", d, v);
    end
    low_power_enter <= 1'b1;
    @(posedge mclk);
    low_power_enter <= 1'b0;
    rd(A_FMT, v);
    chk("format low power", 8'h00, v);
    // Transmit nine framing variants; case 1 has bit 7 set
    wr(A_RATE, 8'h03);
    foreach (fm[i]) begin
      m = 1'($urandom);
      d = (i == 1) ? 8'hA5 : 8'($urandom);
      wr(A_CTRL, {5'h00, m, 2'b11});
      wr(A_FMT, fm[i]);
      n = frame(fm[i], d, m, e);
      wr(A_HOLD, d);
      if (fm[i][7])
        cap_sync(g);
      else
        cap_async(n, g);
      chk("tx frame", e, g);
      chk("tx extra", e[11:8], g[11:8]);
      chk("tx stops", e[12:8], g[12:8]);
    end
    // Bit period for each prescaler code with bitrate 1
    wr(A_RATE, 8'h01);
    for (int cs = 0; cs < 4; cs++) begin
      wr(A_FMT, 8'(cs));
      wr(A_HOLD, 8'h55);
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, n);
      chk("bit period", 32'(2 << (2 * cs)), 32'(n));
      repeat (20 << (2 * cs)) @(posedge mclk);
    end
    // Receive with even and odd parity, good and spoiled, then with
    // the multiprocessor bit in seven- and eight-bit characters
    wr(A_RATE, 8'h03);
    for (int k = 0; k < 6; k++) begin
      f = k[2] ? {1'b0, ~k[0], 6'h04} : (k[1] ? 8'h30 : 8'h20);
      wr(A_FMT, f);
      d = 8'($urandom);
      n = frame(f, d, k[0], e);
      e[9] = e[9] ^ (k[0] && !k[2]);
      a = {2'h0, k[2] & k[0], 1'b0, !k[2] & k[0], 3'h4};
      peer.send(e, n, P);
      repeat (P) @(posedge mclk);
      rd(A_STAT, v);
      chk("rx status", a, v & 8'h3C);
      rd(A_RXD, v);
      chk("rx data", f[6] ? {1'b0, d[6:0]} : d, v);
      wr(A_STAT, 8'h18);
    end
    // Two stop bits set, but characters sent with one: the 0 after
    // the first stop must start the next character
    wr(A_FMT, 8'h08);
    a = 8'($urandom);
    d = 8'($urandom);
    n = frame(8'h00, a, 1'b0, e);
    n = frame(8'h00, d, 1'b0, g);
    fork
      peer.send({2'b11, g[9:0], e[9:0]}, 20, P);
      begin
        repeat (11 * P) @(posedge mclk);
        rd(A_RXD, v);
        chk("rx first", a, v);
      end
    join
    repeat (P) @(posedge mclk);
    rd(A_RXD, v);
    chk("rx second", d, v);
    rd(A_STAT, v);
    chk("rx framing", 8'h00, v & 8'h10);
    final_report();
  end
endmodule
